// ---- shared/dwif_pkg.sv ----
// Shared constants and types for the deviation warning and input force block
package dwif_pkg;

	// ==========================================================
	// Register map (byte addresses on the AXI4-Lite slave)
	localparam int          DWIF_ADDR_W     = 8;
	localparam logic [7:0]  DWIF_OFS_LEVEL  = 8'h00;
	localparam logic [7:0]  DWIF_OFS_AUTO   = 8'h04;
	localparam logic [7:0]  DWIF_OFS_FUNC   = 8'h08;
	localparam logic [7:0]  DWIF_OFS_UNIT   = 8'h0C;
	localparam logic [7:0]  DWIF_OFS_MODE   = 8'h10;
	localparam logic [7:0]  DWIF_OFS_STATUS = 8'h14;
	localparam logic [7:0]  DWIF_OFS_MASK   = 8'h18;
	localparam logic [7:0]  DWIF_OFS_STATE  = 8'h1C;

	// ==========================================================
	// Reset values and field layout
	localparam logic [15:0] DWIF_LEVEL_RESET = 16'h0000;
	localparam logic [15:0] DWIF_LEVEL_MAX   = 16'h03E8;
	localparam logic [15:0] DWIF_AUTO_RESET  = 16'h0000;
	localparam logic [15:0] DWIF_FUNC_RESET  = 16'h0000;
	localparam int          DWIF_FUNC_WARN_EN_BIT = 8;

	// Forceable inputs: index in the forced word and bit in the auto-on word
	localparam int DWIF_N_FORCE = 6;
	localparam int DWIF_IN_SERVO = 0;
	localparam int DWIF_IN_PROP  = 1;
	localparam int DWIF_FORCE_BIT [DWIF_N_FORCE] = '{2, 4, 5, 10, 11, 12};

	// Control modes and which forced inputs each one honours
	typedef enum logic [1:0] {
		DWIF_MODE_POS  = 2'b00,
		DWIF_MODE_SPD  = 2'b01,
		DWIF_MODE_TRQ  = 2'b10,
		DWIF_MODE_PROF = 2'b11
	} dwif_mode_t;
	localparam logic [5:0] DWIF_AVAIL [4] = '{6'h3E, 6'h3F, 6'h21, 6'h3E};

	// Level units; droop and thresholds are counted in 0.001 rev
	typedef enum logic [1:0] {
		DWIF_UNIT_1REV   = 2'b00,
		DWIF_UNIT_0P1    = 2'b01,
		DWIF_UNIT_0P01   = 2'b10,
		DWIF_UNIT_0P001  = 2'b11
	} dwif_unit_t;
	localparam logic [31:0] DWIF_SCALE_1REV  = 32'h0000_03E8;
	localparam logic [31:0] DWIF_SCALE_0P1   = 32'h0000_0064;
	localparam logic [31:0] DWIF_SCALE_0P01  = 32'h0000_000A;
	localparam logic [31:0] DWIF_SCALE_0P001 = 32'h0000_0001;
	localparam logic [31:0] DWIF_ONE_REV     = 32'h0000_03E8;
	localparam logic [31:0] DWIF_MAX_REV     = 32'h0003_0D40;

	// Warning sequencer states
	typedef enum logic [1:0] {
		DWIF_W_IDLE  = 2'b00,
		DWIF_W_HOLD  = 2'b01,
		DWIF_W_ARMED = 2'b10
	} dwif_warn_state_t;

	// Interrupt status bits
	localparam int DWIF_N_STATUS   = 3;
	localparam int DWIF_ST_WARN_ON = 0;
	localparam int DWIF_ST_WARN_OFF = 1;
	localparam int DWIF_ST_PERR    = 2;

	// Bus responses
	localparam logic [1:0] DWIF_RESP_OKAY   = 2'b00;
	localparam logic [1:0] DWIF_RESP_SLVERR = 2'b10;

	// ==========================================================
	// Timing
	localparam int unsigned DWIF_MIN_PULSE_MS   = 100;
	localparam int unsigned DWIF_CLK_PERIOD_NS  = 4;
	localparam int unsigned DWIF_MIN_PULSE_NS   = DWIF_MIN_PULSE_MS * 1000000;
	localparam int unsigned DWIF_MIN_PULSE_CYC  =
		(DWIF_MIN_PULSE_NS + DWIF_CLK_PERIOD_NS - 1) / DWIF_CLK_PERIOD_NS;

endpackage

// ---- design/dwif_warn.sv ----
// Droop comparator with minimum pulse width for the deviation warning
`timescale 1ns/1ps
module dwif_warn #(
	parameter int unsigned MIN_PULSE_CYCLES = dwif_pkg::DWIF_MIN_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Settings
	input  wire logic        enable,
	input  wire logic [15:0] level,
	input  wire logic [1:0]  unit,
	// Measured droop in 0.001 rev
	input  wire logic [31:0] droop,
	// Result
	output logic             warning
);
	localparam int CW = $clog2(MIN_PULSE_CYCLES + 1);

	dwif_pkg::dwif_warn_state_t state;
	dwif_pkg::dwif_warn_state_t next_state;
	logic [CW-1:0]              cnt;
	logic [CW-1:0]              next_cnt;
	logic                       next_warning;

	// ==========================================================
	// Threshold: scale by unit, zero means one rev, clamp at 200 rev
	wire [31:0] lvl32  = {16'h0000, level};
	wire [31:0] scale  = (unit == dwif_pkg::DWIF_UNIT_1REV) ? dwif_pkg::DWIF_SCALE_1REV :
	                     (unit == dwif_pkg::DWIF_UNIT_0P1)  ? dwif_pkg::DWIF_SCALE_0P1 :
	                     (unit == dwif_pkg::DWIF_UNIT_0P01) ? dwif_pkg::DWIF_SCALE_0P01 :
	                     dwif_pkg::DWIF_SCALE_0P001; // see (R2)
	wire [31:0] scaled = lvl32 * scale;
	wire [31:0] thresh = (level == 16'h0000) ? dwif_pkg::DWIF_ONE_REV :   // see (R3)
	                     (scaled > dwif_pkg::DWIF_MAX_REV) ? dwif_pkg::DWIF_MAX_REV :
	                     scaled; // see (R4)
	wire        over   = enable && (droop >= thresh); // see (R1) (R5)

	// ==========================================================
	// Sequencer: hold high for the minimum width, then follow the droop
	always_comb begin
		next_state   = state;
		next_cnt     = cnt;
		next_warning = warning;
		case (state)
			dwif_pkg::DWIF_W_IDLE: begin
				if (over) begin
					next_state   = dwif_pkg::DWIF_W_HOLD;
					next_cnt     = CW'(MIN_PULSE_CYCLES - 1); // see (R7)
					next_warning = 1'b1; // see (R5)
				end
			end
			dwif_pkg::DWIF_W_HOLD: begin
				// Disabling cuts the pulse short: no warning while disabled
				if (!enable) begin
					next_state   = dwif_pkg::DWIF_W_IDLE;
					next_warning = 1'b0; // see (R1)
				end else if (cnt != '0) begin
					next_cnt = cnt - CW'(1); // see (R7)
				end else if (over) begin
					next_state = dwif_pkg::DWIF_W_ARMED;
				end else begin
					next_state   = dwif_pkg::DWIF_W_IDLE;
					next_warning = 1'b0; // see (R6)
				end
			end
			dwif_pkg::DWIF_W_ARMED: begin
				if (!over) begin
					next_state   = dwif_pkg::DWIF_W_IDLE;
					next_warning = 1'b0; // see (R6)
				end
			end
			default: begin
				next_state   = dwif_pkg::DWIF_W_IDLE;
				next_warning = 1'b0;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state   <= dwif_pkg::DWIF_W_IDLE;
			cnt     <= '0;
			warning <= 1'b0;
		end else begin
			state   <= next_state;
			cnt     <= next_cnt;
			warning <= next_warning;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	warn_disabled_a: assert property (!enable |=> !warning) // see (R1)
		else $error("warning raised while disabled");
	unit_scale_a: assert property ((unit == dwif_pkg::DWIF_UNIT_0P1) && (level == 16'h0005)
		|-> thresh == 32'h0000_01F4) // see (R2)
		else $error("unit scaling wrong");
	zero_level_a: assert property ((level == 16'h0000) |-> thresh == 32'h0000_03E8) // see (R3)
		else $error("zero level not one rev");
	clamp_level_a: assert property ((unit == dwif_pkg::DWIF_UNIT_1REV) && (level > 16'h00C8)
		|-> thresh == 32'h0003_0D40) // see (R4)
		else $error("level not clamped");
	warn_raise_a: assert property (enable && (droop >= thresh) |=> warning) // see (R5)
		else $error("warning missed");
	warn_clear_a: assert property ((state == dwif_pkg::DWIF_W_ARMED) && (droop < thresh)
		|=> !warning) // see (R6)
		else $error("warning did not self clear");
	warn_width_a: assert property ($fell(warning) && $past(enable) |-> $past(cnt) == '0) // see (R7)
		else $error("warning shorter than minimum");
endmodule

// ---- design/dwif_top.sv ----
// Deviation warning and input auto-on block with AXI4-Lite registers
//
// Summary of operation
// (R1) Deviation warning only works when the function select enable bit is set.
// (R2) Warning level is scaled by the level unit selection.
// (R3) A warning level of zero acts as one revolution.
// (R4) Levels above 200 revolutions are clamped to 200 revolutions.
// (R5) Warning rises once droop reaches or exceeds the threshold.
// (R6) Warning clears by itself once droop drops below the threshold.
// (R7) Each warning pulse lasts at least 100 ms; the code cuts it short when the enable bit clears.
// (R8) Software keeps the warning level below the deviation alarm level.
// (R9) Warning level accepts 0 to 1000 and resets to zero.
// (R10) A register selects input functions that are forced permanently on.
// (R11) Select bit zero uses the pin, one forces the function on.
// (R12) Six forceable inputs, each honoured only in its own control modes.
// (R13) Servo enable forced while in profile mode raises the parameter error alarm.
// (R14) Software leaves reserved auto-on bits at zero.
// (R15) Auto-on bits: servo 2, proportional 4, torque 5, fwd 10, rev 11, stop 12.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module dwif_top #(
	parameter int unsigned MIN_PULSE_CYCLES = dwif_pkg::DWIF_MIN_PULSE_CYC
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Position loop droop magnitude in 0.001 rev
	input  wire logic [31:0] droop_mrev,
	// External input pins: servo, proportional, torque limit, fwd/rev stroke, stop
	input  wire logic [5:0]  input_pins,
	// Results
	output logic             deviation_warning,
	output logic             parameter_error_alarm,
	output logic [5:0]       forced_input_word,
	output logic             irq
);
	// ==========================================================
	// Registers
	logic [15:0]                deviation_warning_level;
	logic [15:0]                input_auto_on_select;
	logic [15:0]                function_select_cd;
	dwif_pkg::dwif_unit_t       level_unit_select;
	dwif_pkg::dwif_mode_t       control_mode;
	logic [2:0]                 irq_status;
	logic [2:0]                 irq_mask;
	// Write channel holding state
	logic [7:0]                 aw_addr;
	logic [31:0]                w_data;
	logic [3:0]                 w_strb;
	// Pin synchronisers and edge history
	logic [5:0]                 pin_s1;
	logic [5:0]                 pin_s2;
	logic                       warn_q;
	logic                       perr_q;
	logic                       warn_out;

	// Byte lane merge for 16-bit registers
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) res[7:0] = data[7:0];
		if (strb[1]) res[15:8] = data[15:8];
		return res;
	endfunction

	// ==========================================================
	// Write decode: both halves held, no response pending
	wire        wr_go      = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire        sel_level  = (aw_addr == dwif_pkg::DWIF_OFS_LEVEL);
	wire        sel_auto   = (aw_addr == dwif_pkg::DWIF_OFS_AUTO);
	wire        sel_func   = (aw_addr == dwif_pkg::DWIF_OFS_FUNC);
	wire        sel_unit   = (aw_addr == dwif_pkg::DWIF_OFS_UNIT);
	wire        sel_mode   = (aw_addr == dwif_pkg::DWIF_OFS_MODE);
	wire        sel_mask   = (aw_addr == dwif_pkg::DWIF_OFS_MASK);
	wire        sel_ro     = (aw_addr == dwif_pkg::DWIF_OFS_STATUS) ||
	                         (aw_addr == dwif_pkg::DWIF_OFS_STATE);
	wire [15:0] lvl_merge  = merge16(deviation_warning_level, w_data, w_strb);
	wire [15:0] auto_merge = merge16(input_auto_on_select, w_data, w_strb);
	wire [15:0] func_merge = merge16(function_select_cd, w_data, w_strb);
	// Out-of-range levels are refused so the register never leaves 0..1000
	wire        lvl_bad    = sel_level && (lvl_merge > dwif_pkg::DWIF_LEVEL_MAX); // see (R9)
	wire        wr_unmap   = !(sel_level || sel_auto || sel_func || sel_unit ||
	                           sel_mode || sel_mask || sel_ro);
	wire        wr_err     = wr_unmap || lvl_bad;
	wire        wr_ok      = wr_go && !wr_err;
	// Narrow fields live in byte lane 0; a write without that lane keeps them
	wire        lo_lane    = w_strb[0];

	// Write channel handshakes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dwif_pkg::DWIF_RESP_OKAY;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_err ? dwif_pkg::DWIF_RESP_SLVERR : dwif_pkg::DWIF_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Software-visible settings
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			deviation_warning_level <= dwif_pkg::DWIF_LEVEL_RESET; // see (R9)
			input_auto_on_select    <= dwif_pkg::DWIF_AUTO_RESET;
			function_select_cd      <= dwif_pkg::DWIF_FUNC_RESET;
			level_unit_select       <= dwif_pkg::DWIF_UNIT_1REV;
			control_mode            <= dwif_pkg::DWIF_MODE_POS;
			irq_mask                <= 3'h0;
		end else if (wr_ok) begin
			if (sel_level) deviation_warning_level <= lvl_merge; // see (R9)
			if (sel_auto) input_auto_on_select <= auto_merge; // see (R10)
			if (sel_func) function_select_cd <= func_merge;
			if (sel_unit && lo_lane) level_unit_select <= dwif_pkg::dwif_unit_t'(w_data[1:0]);
			if (sel_mode && lo_lane) control_mode <= dwif_pkg::dwif_mode_t'(w_data[1:0]);
			if (sel_mask && lo_lane) irq_mask <= w_data[2:0];
		end
	end

	// ==========================================================
	// Deviation warning
	wire warn_enable = function_select_cd[dwif_pkg::DWIF_FUNC_WARN_EN_BIT]; // see (R1)

	dwif_warn #(
		.MIN_PULSE_CYCLES (MIN_PULSE_CYCLES)
	) u_warn (
		.clk_sys (clk_sys),
		.rst     (rst),
		.enable  (warn_enable),
		.level   (deviation_warning_level),
		.unit    (level_unit_select),
		.droop   (droop_mrev),
		.warning (warn_out)
	);
	assign deviation_warning = warn_out;

	// ==========================================================
	// Input auto-on: availability depends on the control mode
	wire [5:0] avail = dwif_pkg::DWIF_AVAIL[control_mode]; // see (R12)
	wire [5:0] force_eff;
	wire [5:0] next_forced;

	genvar gi;
	generate
		for (gi = 0; gi < dwif_pkg::DWIF_N_FORCE; gi++) begin : g_force
			// Bit one forces the function on in modes that allow it, zero passes the pin through
			assign force_eff[gi] = avail[gi] &&
				input_auto_on_select[dwif_pkg::DWIF_FORCE_BIT[gi]]; // see (R15) (R12)
			assign next_forced[gi] = force_eff[gi] || pin_s2[gi]; // see (R11)
		end
	endgenerate

	// Servo enable cannot be forced in profile mode
	wire next_perr = (control_mode == dwif_pkg::DWIF_MODE_PROF) &&
		input_auto_on_select[dwif_pkg::DWIF_FORCE_BIT[dwif_pkg::DWIF_IN_SERVO]]; // see (R13)

	// Pins cross in through two flops; outputs come straight from flops
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_s1                <= 6'h00;
			pin_s2                <= 6'h00;
			forced_input_word     <= 6'h00;
			parameter_error_alarm <= 1'b0;
		end else begin
			pin_s1                <= input_pins;
			pin_s2                <= pin_s1;
			forced_input_word     <= next_forced; // see (R11)
			parameter_error_alarm <= next_perr; // see (R13)
		end
	end

	// ==========================================================
	// Interrupts: sticky events, cleared by reading status, set wins
	wire       rd_take  = s_axi_arvalid && s_axi_arready;
	wire       st_clr   = rd_take && (s_axi_araddr == dwif_pkg::DWIF_OFS_STATUS);
	wire [2:0] ev;
	assign ev[dwif_pkg::DWIF_ST_WARN_ON]  = warn_out && !warn_q;
	assign ev[dwif_pkg::DWIF_ST_WARN_OFF] = !warn_out && warn_q;
	assign ev[dwif_pkg::DWIF_ST_PERR]     = parameter_error_alarm && !perr_q;
	// An event in the clearing cycle survives, so no edge is ever lost
	wire [2:0] next_status = (st_clr ? 3'h0 : irq_status) | ev;

	// Event history and interrupt line
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			warn_q     <= 1'b0;
			perr_q     <= 1'b0;
			irq_status <= 3'h0;
			irq        <= 1'b0;
		end else begin
			warn_q     <= warn_out;
			perr_q     <= parameter_error_alarm;
			irq_status <= next_status;
			irq        <= |(next_status & irq_mask);
		end
	end

	// ==========================================================
	// Read path: one-cycle answer, unmapped reads give zero and SLVERR
	wire [31:0] state_word = {22'h0, parameter_error_alarm, deviation_warning,
	                          2'b00, forced_input_word};
	wire        rd_map = (s_axi_araddr <= dwif_pkg::DWIF_OFS_STATE) && (s_axi_araddr[1:0] == 2'b00);
	wire [31:0] rd_data =
		(s_axi_araddr == dwif_pkg::DWIF_OFS_LEVEL)  ? {16'h0000, deviation_warning_level} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_AUTO)   ? {16'h0000, input_auto_on_select} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_FUNC)   ? {16'h0000, function_select_cd} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_UNIT)   ? {30'h0, level_unit_select} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_MODE)   ? {30'h0, control_mode} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_STATUS) ? {29'h0, irq_status} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_MASK)   ? {29'h0, irq_mask} :
		(s_axi_araddr == dwif_pkg::DWIF_OFS_STATE)  ? state_word :
		32'h0000_0000;

	// Read channel handshakes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= dwif_pkg::DWIF_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_map ? dwif_pkg::DWIF_RESP_OKAY : dwif_pkg::DWIF_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	level_range_a: assert property (deviation_warning_level <= 16'h03E8) // see (R9)
		else $error("warning level out of range");
	level_refuse_a: assert property (wr_go && lvl_bad
		|=> s_axi_bvalid && (s_axi_bresp == 2'b10) && $stable(deviation_warning_level)) // see (R9)
		else $error("bad level write accepted");
	son_force_a: assert property (force_eff[0] // see (R11) (R15)
		|=> forced_input_word[0] && $past(input_auto_on_select[2]))
		else $error("forced servo enable not on");
	pin_pass_a: assert property (!force_eff[1] // see (R11)
		|=> forced_input_word[1] == $past(pin_s2[1]))
		else $error("pin not passed through");
	trq_mode_a: assert property ((control_mode == dwif_pkg::DWIF_MODE_TRQ) && !pin_s2[1]
		|=> !forced_input_word[1]) // see (R12)
		else $error("input forced in wrong mode");
	prof_perr_a: assert property ((control_mode == dwif_pkg::DWIF_MODE_PROF) &&
		input_auto_on_select[2] |=> parameter_error_alarm) // see (R13)
		else $error("parameter error missing");
	prof_perr_clear_a: assert property ((control_mode != dwif_pkg::DWIF_MODE_PROF)
		|=> !parameter_error_alarm) // see (R13)
		else $error("spurious parameter error");
	warn_gate_a: assert property (!warn_enable ##1 !warn_enable |-> !deviation_warning) // see (R1)
		else $error("warning while function disabled");
endmodule

// ---- dv/dwif_far.sv ----
// Behavioural model of the input pins and the droop measurement
`timescale 1ns/1ps
module dwif_far (
	// Clock
	input  wire logic        clk_sys,
	// Values requested by the bench
	input  wire logic [31:0] droop_set,
	input  wire logic [5:0]  pins_set,
	// Driven toward the block
	output logic      [31:0] droop_mrev,
	output logic      [5:0]  input_pins
);
	// Update just after an edge, like a sampled position loop
	always_ff @(posedge clk_sys) begin
		droop_mrev <= droop_set;
		input_pins <= pins_set;
	end
endmodule

// ---- dv/dwif_top_tb.sv ----
// Self-checking bench for the deviation warning and input force block
`timescale 1ns/1ps
module dwif_top_tb;
	localparam int MINP = 20;
	logic        clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, warn, perr, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, droop_set, droop_mrev, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [5:0]  pins_set, input_pins, fword;
	int          err_count, checks, cyc;

	// ==========================================================
	// Design, far side and clock
	dwif_top #(.MIN_PULSE_CYCLES(MINP)) DUT (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .droop_mrev(droop_mrev),
		.input_pins(input_pins), .deviation_warning(warn),
		.parameter_error_alarm(perr), .forced_input_word(fword), .irq(irq));
	dwif_far far (.clk_sys(clk_sys), .droop_set(droop_set), .pins_set(pins_set),
		.droop_mrev(droop_mrev), .input_pins(input_pins));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Each channel is released at the edge where its own ready is seen
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		@(posedge clk_sys);
		awaddr <= a; awvalid <= 1'b1; wdata <= v; wvalid <= 1'b1; bready <= 1'b1;
		while (aw || w) begin
			@(posedge clk_sys);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge clk_sys);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk_sys);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk_sys);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	// Droop goes to the far side, then lets the comparator settle
	task automatic step(input logic [31:0] v, input logic exp, input string nm);
		droop_set <= v;
		repeat (5) @(posedge clk_sys);
		chk(nm, {31'h0, warn}, {31'h0, exp});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		rd(dwif_pkg::DWIF_OFS_LEVEL, d, r); chk("level reset", d, 32'h0);
		rd(dwif_pkg::DWIF_OFS_AUTO, d, r); chk("auto reset", d, 32'h0);
		rd(8'h20, d, r); chk("unmapped resp", r, dwif_pkg::DWIF_RESP_SLVERR);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0000_03E9, r); chk("over 1000", r, 2'b10);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0000_03E8, r); chk("1000 ok", r, 2'b00);
		rd(dwif_pkg::DWIF_OFS_LEVEL, d, r); chk("level 1000", d, 32'h0000_03E8);
		$display("test regs done");
	endtask
	task automatic t_warn();
		int n;
		n = 0;
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0, r);
		step(32'h0001_0000, 1'b0, "disabled");
		step(32'h0, 1'b0, "idle");
		wr(dwif_pkg::DWIF_OFS_FUNC, 32'h0000_0100, r);
		step(32'h0000_03E7, 1'b0, "zero level below");
		droop_set <= 32'h0000_03E8;
		while (!warn && n < 10) begin
			@(posedge clk_sys);
			n++;
		end
		chk("rise at 1 rev", {31'h0, warn}, 32'h1);
		droop_set <= 32'h0;
		n = 0;
		while (warn && n < 100) begin
			@(posedge clk_sys);
			n++;
		end
		chk("min pulse", {31'h0, n >= MINP}, 32'h1);
		chk("self clear", {31'h0, n <= MINP + 4}, 32'h1);
		chk("masked irq", {31'h0, irq}, 32'h0);
		wr(dwif_pkg::DWIF_OFS_MASK, 32'h3, r);
		repeat (2) @(posedge clk_sys);
		chk("irq on", {31'h0, irq}, 32'h1);
		rd(dwif_pkg::DWIF_OFS_STATUS, d, r); chk("status", d, 32'h3);
		repeat (2) @(posedge clk_sys);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		$display("test warn done");
	endtask
	task automatic t_scale();
		wr(dwif_pkg::DWIF_OFS_UNIT, 32'h1, r);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h5, r);
		step(32'h0000_01F3, 1'b0, "0.1 below");
		step(32'h0000_01F4, 1'b1, "0.1 at");
		step(32'h0, 1'b1, "held");
		repeat (MINP + 5) @(posedge clk_sys);
		wr(dwif_pkg::DWIF_OFS_UNIT, 32'h2, r);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0000_0019, r);
		step(32'h0000_00F9, 1'b0, "0.01 below");
		step(32'h0000_00FA, 1'b1, "0.01 at");
		step(32'h0, 1'b1, "held");
		repeat (MINP + 5) @(posedge clk_sys);
		wr(dwif_pkg::DWIF_OFS_UNIT, 32'h3, r);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0000_00FA, r);
		step(32'h0000_00F9, 1'b0, "0.001 below");
		step(32'h0000_00FA, 1'b1, "0.001 at");
		step(32'h0, 1'b1, "held");
		repeat (MINP + 5) @(posedge clk_sys);
		wr(dwif_pkg::DWIF_OFS_UNIT, 32'h0, r);
		wr(dwif_pkg::DWIF_OFS_LEVEL, 32'h0000_03E8, r);
		step(32'h0003_0D3F, 1'b0, "clamp below");
		step(32'h0003_0D40, 1'b1, "clamp at");
		step(32'h0, 1'b1, "held");
		repeat (MINP + 5) @(posedge clk_sys);
		$display("test scale done");
	endtask
	task automatic t_force();
		wr(dwif_pkg::DWIF_OFS_MODE, 32'h1, r);
		wr(dwif_pkg::DWIF_OFS_AUTO, 32'h0000_1C34, r);
		repeat (4) @(posedge clk_sys);
		chk("speed forced", {26'h0, fword}, 32'h3F);
		wr(dwif_pkg::DWIF_OFS_MODE, 32'h2, r);
		repeat (4) @(posedge clk_sys);
		chk("torque forced", {26'h0, fword}, 32'h21);
		wr(dwif_pkg::DWIF_OFS_MODE, 32'h3, r);
		repeat (4) @(posedge clk_sys);
		chk("profile forced", {26'h0, fword}, 32'h3E);
		chk("param error", {31'h0, perr}, 32'h1);
		rd(dwif_pkg::DWIF_OFS_STATE, d, r);
		chk("state word", d, 32'h0000_023E);
		rd(dwif_pkg::DWIF_OFS_STATUS, d, r);
		chk("status all", d, 32'h7);
		wr(dwif_pkg::DWIF_OFS_MODE, 32'h0, r);
		repeat (4) @(posedge clk_sys);
		chk("position forced", {26'h0, fword}, 32'h3E);
		wr(dwif_pkg::DWIF_OFS_AUTO, 32'h0, r);
		pins_set <= 6'h15;
		repeat (6) @(posedge clk_sys);
		chk("pins pass", {26'h0, fword}, 32'h15);
		chk("param error off", {31'h0, perr}, 32'h0);
		$display("test force done");
	endtask

	// ==========================================================
	// Hang guard and main sequence
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			end_sim();
		end
	end
	initial begin
		err_count = 0; checks = 0; cyc = 0;
		rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
		droop_set = 32'h0; pins_set = 6'h00;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		t_regs();
		t_warn();
		t_scale();
		t_force();
		end_sim();
	end
endmodule
